// ==== shared/fscr_pkg.sv ====
package fscr_pkg;

	localparam int CLK_MHZ = 100;

	// status_one field positions
	localparam int S1_BUSY = 0;
	localparam int S1_WEN = 1;
	localparam int S1_BP_LSB = 2;
	localparam int S1_E_ERR = 5;
	localparam int S1_P_ERR = 6;
	localparam int S1_WRDIS = 7;

	// configuration_one field positions
	localparam int C1_FREEZE = 0;
	localparam int C1_QUAD = 1;
	localparam int C1_PARM_PLACE = 2;
	localparam int C1_BP_VOL = 3;
	localparam int C1_PROT_PLACE = 5;
	localparam int C1_LAT_LSB = 6;

	// status_two field positions
	localparam int S2_PROG_SUSP = 0;
	localparam int S2_ERASE_SUSP = 1;

	// reset values and field groups
	localparam logic [7:0] S1_RST = 8'h00;
	localparam logic [7:0] C1_RST = 8'h00;
	localparam logic [7:0] S2_RST = 8'h00;
	localparam logic [2:0] BP_VOLATILE_RST = 3'h7;
	localparam logic [7:0] C1_NV_MASK = 8'hc2;
	localparam logic [7:0] C1_OTP_FREE_MASK = 8'h08;
	localparam logic [7:0] C1_OTP_FRZ_MASK = 8'h24;
	localparam logic [7:0] C1_FREEZE_MASK = 8'h01;

	// apb byte offsets
	localparam logic [7:0] OFS_STATUS_ONE = 8'h00;
	localparam logic [7:0] OFS_CONFIG_ONE = 8'h04;
	localparam logic [7:0] OFS_STATUS_TWO = 8'h08;
	localparam logic [7:0] OFS_INT_STATUS = 8'h0c;
	localparam logic [7:0] OFS_INT_CLEAR = 8'h10;
	localparam logic [7:0] OFS_INT_ENABLE = 8'h14;

	// interrupt bit positions
	localparam int INT_P_ERR = 0;
	localparam int INT_E_ERR = 1;
	localparam int INT_REGW_DONE = 2;
	localparam int INT_REFUSED = 3;
	localparam int INT_W = 4;
	localparam logic [INT_W-1:0] INT_RST = 4'h0;

	// link command codes
	localparam logic [2:0] CMD_WEN_SET = 3'h0;
	localparam logic [2:0] CMD_WEN_CLR = 3'h1;
	localparam logic [2:0] CMD_REGW = 3'h2;
	localparam logic [2:0] CMD_PROG = 3'h3;
	localparam logic [2:0] CMD_ERASE = 3'h4;
	localparam logic [2:0] CMD_CLR_ERR = 3'h5;

	// register write busy time
	localparam int REGW_BUSY_NS = 1000;
	localparam int REGW_BUSY_CYCLES = (REGW_BUSY_NS * CLK_MHZ + 999) / 1000;

endpackage

// ==== rtl/fscr_sync.sv ====
`timescale 1ns/1ps
module fscr_sync #(
	parameter int WIDTH = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;

	// first stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= '0;
			sync_out <= '0;
		end else begin
			meta_ff <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule

// ==== rtl/fscr_regs.sv ====
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
module fscr_regs
	import fscr_pkg::*;
#(
	parameter int REGW_CYCLES = REGW_BUSY_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic wp_n,
	input wire logic link_clk,
	input wire logic link_valid,
	input wire logic [2:0] link_cmd,
	input wire logic [15:0] link_data,
	input wire logic [7:0] nv_status_image,
	input wire logic [7:0] nv_config_image,
	input wire logic core_busy,
	input wire logic core_prog_err,
	input wire logic core_erase_err,
	input wire logic core_prog_susp,
	input wire logic core_erase_susp,
	output logic core_prog_start,
	output logic core_erase_start,
	output logic [1:0] latency_code,
	output logic protect_range_placement,
	output logic protect_bits_volatility,
	output logic param_sector_placement,
	output logic quad_enable,
	output logic freeze_lock,
	output logic [2:0] block_protect,
	output logic write_in_progress
);
	localparam int CW = $clog2(REGW_CYCLES + 1);
	localparam int LW = 21;

	////////////////////////////////////////////////////////////////////////////////
	// link pins into the pclk domain

	logic [LW-1:0] link_sync;
	logic wp_n_sync;
	logic link_clk_d_ff;
	logic nxt_link_clk_d;

	fscr_sync #(.WIDTH(LW)) u_link_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({link_clk, link_valid, link_cmd, link_data}),
		.sync_out(link_sync)
	);

	fscr_sync #(.WIDTH(1)) u_wp_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(wp_n),
		.sync_out(wp_n_sync)
	);

	logic link_take;
	logic [2:0] cmd_s;
	logic [15:0] data_s;
	// host changes data on the falling edge, so it is settled at the rising one
	assign link_take = link_sync[20] && !link_clk_d_ff && link_sync[19];
	assign cmd_s = link_sync[18:16];
	assign data_s = link_sync[15:0];

	////////////////////////////////////////////////////////////////////////////////
	// state

	logic load_ff, nxt_load;
	logic wrdis_ff, nxt_wrdis;
	logic perr_ff, nxt_perr;
	logic eerr_ff, nxt_eerr;
	logic [2:0] bp_ff, nxt_bp;
	logic wen_ff, nxt_wen;
	logic [7:0] cfg1_ff, nxt_cfg1;
	logic [CW-1:0] regw_cnt_ff, nxt_regw_cnt;
	logic busy_bit_ff, nxt_busy_bit;
	logic prog_start_ff, nxt_prog_start;
	logic erase_start_ff, nxt_erase_start;
	logic [INT_W-1:0] int_stat_ff, nxt_int_stat;
	logic [INT_W-1:0] int_en_ff, nxt_int_en;
	logic irq_ff, nxt_irq;
	logic [31:0] prdata_ff, nxt_prdata;
	logic pready_ff, nxt_pready;
	logic pslverr_ff, nxt_pslverr;
	logic [7:0] st1_view, st2_view;
	logic busy;
	logic [INT_W-1:0] ev;
	logic regw_ok;
	logic apb_setup, apb_wr;

	assign st1_view = {wrdis_ff, perr_ff, eerr_ff, bp_ff, wen_ff, busy_bit_ff};
	assign st2_view = {6'h00, core_erase_susp, core_prog_susp};
	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pready_ff && pwrite && pstrb[0];
	// power-up load, register write, core operation or a start in flight
	assign busy = load_ff || (regw_cnt_ff != '0) || core_busy || prog_start_ff
		|| erase_start_ff;
	assign regw_ok = wen_ff && !busy && !(wrdis_ff && !wp_n_sync);

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		nxt_link_clk_d = link_sync[20];
		nxt_load = 1'b0;
		nxt_wrdis = wrdis_ff;
		nxt_perr = perr_ff;
		nxt_eerr = eerr_ff;
		nxt_bp = bp_ff;
		nxt_wen = wen_ff;
		nxt_cfg1 = cfg1_ff;
		nxt_regw_cnt = regw_cnt_ff;
		nxt_prog_start = 1'b0;
		nxt_erase_start = 1'b0;
		nxt_int_en = int_en_ff;
		ev = '0;

		// non-volatile image is caught once, the cycle after reset release
		if (load_ff) begin
			nxt_wrdis = nv_status_image[S1_WRDIS];
			nxt_cfg1 = nv_config_image & (C1_NV_MASK | C1_OTP_FREE_MASK | C1_OTP_FRZ_MASK);
			if (nv_config_image[C1_BP_VOL]) begin
				nxt_bp = BP_VOLATILE_RST;
			end else begin
				nxt_bp = nv_status_image[S1_BP_LSB +: 3];
			end
		end

		if (regw_cnt_ff != '0) begin
			nxt_regw_cnt = regw_cnt_ff - 1'b1;
			ev[INT_REGW_DONE] = (regw_cnt_ff == CW'(1));
		end

		if (link_take) begin
			unique case (cmd_s)
				CMD_WEN_SET: begin
					nxt_wen = 1'b1;
				end
				CMD_WEN_CLR: begin
					nxt_wen = 1'b0;
				end
				CMD_CLR_ERR: begin
					nxt_perr = 1'b0;
					nxt_eerr = 1'b0;
				end
				CMD_REGW: begin
					if (regw_ok) begin
						nxt_wrdis = data_s[8 + S1_WRDIS];
						if (!cfg1_ff[C1_FREEZE]) begin
							nxt_bp = data_s[8 + S1_BP_LSB +: 3];
						end
						// one-time bits only ever set; placement bits obey freeze
						nxt_cfg1 = (cfg1_ff & ~C1_NV_MASK) | (data_s[7:0] & C1_NV_MASK)
							| (data_s[7:0] & (C1_OTP_FREE_MASK | C1_FREEZE_MASK));
						if (!cfg1_ff[C1_FREEZE]) begin
							nxt_cfg1 = nxt_cfg1 | (data_s[7:0] & C1_OTP_FRZ_MASK);
						end
						nxt_regw_cnt = CW'(REGW_CYCLES);
					end else begin
						ev[INT_REFUSED] = 1'b1;
					end
				end
				CMD_PROG: begin
					if (wen_ff && !busy) begin
						nxt_prog_start = 1'b1;
					end else begin
						ev[INT_REFUSED] = 1'b1;
					end
				end
				CMD_ERASE: begin
					if (wen_ff && !busy) begin
						nxt_erase_start = 1'b1;
					end else begin
						ev[INT_REFUSED] = 1'b1;
					end
				end
				default: begin
					ev[INT_REFUSED] = 1'b1;
				end
			endcase
		end

		// error set comes after the clear so it wins
		if (core_prog_err) begin
			nxt_perr = 1'b1;
			ev[INT_P_ERR] = 1'b1;
		end
		if (core_erase_err) begin
			nxt_eerr = 1'b1;
			ev[INT_E_ERR] = 1'b1;
		end

		nxt_busy_bit = nxt_load || (nxt_regw_cnt != '0) || core_busy || nxt_prog_start
			|| nxt_erase_start || prog_start_ff || erase_start_ff;

		// apb: answer prepared in setup, pready high through the access phase
		nxt_pready = apb_setup;
		nxt_pslverr = 1'b0;
		nxt_prdata = 32'h0000_0000;
		if (apb_setup) begin
			unique case (paddr)
				OFS_STATUS_ONE: nxt_prdata = {24'h00_0000, st1_view};
				OFS_CONFIG_ONE: nxt_prdata = {24'h00_0000, cfg1_ff};
				OFS_STATUS_TWO: nxt_prdata = {24'h00_0000, st2_view};
				OFS_INT_STATUS: nxt_prdata = {28'h000_0000, int_stat_ff};
				OFS_INT_CLEAR: nxt_prdata = 32'h0000_0000;
				OFS_INT_ENABLE: nxt_prdata = {28'h000_0000, int_en_ff};
				default: nxt_pslverr = 1'b1;
			endcase
		end

		nxt_int_stat = int_stat_ff;
		if (apb_wr && paddr == OFS_INT_CLEAR) begin
			nxt_int_stat = int_stat_ff & ~pwdata[INT_W-1:0];
		end
		if (apb_wr && paddr == OFS_INT_ENABLE) begin
			nxt_int_en = pwdata[INT_W-1:0];
		end
		nxt_int_stat = nxt_int_stat | ev;
		nxt_irq = |(nxt_int_stat & nxt_int_en);
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_clk_d_ff <= 1'b0;
			load_ff <= 1'b1;
			wrdis_ff <= S1_RST[S1_WRDIS];
			perr_ff <= S1_RST[S1_P_ERR];
			eerr_ff <= S1_RST[S1_E_ERR];
			bp_ff <= S1_RST[S1_BP_LSB +: 3];
			wen_ff <= S1_RST[S1_WEN];
			cfg1_ff <= C1_RST;
			regw_cnt_ff <= '0;
			busy_bit_ff <= 1'b1;
			prog_start_ff <= 1'b0;
			erase_start_ff <= 1'b0;
			int_stat_ff <= INT_RST;
			int_en_ff <= INT_RST;
			irq_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			link_clk_d_ff <= nxt_link_clk_d;
			load_ff <= nxt_load;
			wrdis_ff <= nxt_wrdis;
			perr_ff <= nxt_perr;
			eerr_ff <= nxt_eerr;
			bp_ff <= nxt_bp;
			wen_ff <= nxt_wen;
			cfg1_ff <= nxt_cfg1;
			regw_cnt_ff <= nxt_regw_cnt;
			busy_bit_ff <= nxt_busy_bit;
			prog_start_ff <= nxt_prog_start;
			erase_start_ff <= nxt_erase_start;
			int_stat_ff <= nxt_int_stat;
			int_en_ff <= nxt_int_en;
			irq_ff <= nxt_irq;
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign irq = irq_ff;
	assign core_prog_start = prog_start_ff;
	assign core_erase_start = erase_start_ff;
	assign latency_code = cfg1_ff[C1_LAT_LSB +: 2];
	assign protect_range_placement = cfg1_ff[C1_PROT_PLACE];
	assign protect_bits_volatility = cfg1_ff[C1_BP_VOL];
	assign param_sector_placement = cfg1_ff[C1_PARM_PLACE];
	assign quad_enable = cfg1_ff[C1_QUAD];
	assign freeze_lock = cfg1_ff[C1_FREEZE];
	assign block_protect = bp_ff;
	assign write_in_progress = busy_bit_ff;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	AST_REGW_LOCKED: assert property (@(posedge pclk) disable iff (!presetn)
		(link_take && cmd_s == CMD_REGW && wrdis_ff && !wp_n_sync && !load_ff)
		|=> $stable(wrdis_ff) && $stable(bp_ff) && $stable(cfg1_ff)
		&& regw_cnt_ff != CW'(REGW_CYCLES))
		else $error("register write taken while locked");

	AST_START_NEEDS_WEN: assert property (@(posedge pclk) disable iff (!presetn)
		(prog_start_ff || erase_start_ff) |-> $past(wen_ff) && !$past(busy))
		else $error("program or erase started without write enable");

	AST_WEN_SOURCE: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(wen_ff) |-> $past(link_take)
		&& ($past(cmd_s) == CMD_WEN_SET || $past(cmd_s) == CMD_WEN_CLR))
		else $error("write enable latch moved by another command");

	AST_REGW_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
		(link_take && cmd_s == CMD_REGW && regw_ok)
		|=> regw_cnt_ff == CW'(REGW_CYCLES) ##1 busy_bit_ff)
		else $error("register write did not raise write in progress");

	AST_BUSY_BIT_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
		(!load_ff && regw_cnt_ff == '0 && !core_busy && !prog_start_ff && !erase_start_ff)
		[*2] |-> !busy_bit_ff)
		else $error("write in progress stuck while idle");

	AST_OTP_NO_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		!$past(load_ff) && !load_ff |-> !$fell(cfg1_ff[C1_PROT_PLACE])
		&& !$fell(cfg1_ff[C1_BP_VOL]) && !$fell(cfg1_ff[C1_PARM_PLACE]))
		else $error("one-time configuration bit cleared");

	AST_FREEZE_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg1_ff[C1_FREEZE] && !load_ff) |=> $stable(bp_ff)
		&& $stable(cfg1_ff[C1_PROT_PLACE]) && $stable(cfg1_ff[C1_PARM_PLACE])
		&& cfg1_ff[C1_FREEZE])
		else $error("frozen protection bits changed");

	AST_ST2_READ: assert property (@(posedge pclk) disable iff (!presetn)
		(apb_setup && paddr == OFS_STATUS_TWO) |=> prdata_ff[31:2] == 30'h0000_0000
		&& prdata_ff[1] == $past(core_erase_susp) && prdata_ff[0] == $past(core_prog_susp))
		else $error("status two read value wrong");

	AST_ERR_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
		core_prog_err |=> perr_ff && int_stat_ff[INT_P_ERR])
		else $error("program error not latched");

	AST_APB_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
		apb_setup |=> pready_ff ##1 !pready_ff)
		else $error("apb answer not one cycle after setup");
endmodule

// ==== bench/fscr_host.sv ====
`timescale 1ns/1ps
module fscr_host (
	output logic link_clk,
	output logic link_valid,
	output logic [2:0] link_cmd,
	output logic [15:0] link_data
);
	initial begin
		link_clk = 1'b0;
		link_valid = 1'b0;
		link_cmd = 3'h7;
		link_data = 16'hffff;
	end

	// clock stands still between frames; released lines show the inverse
	// so a stale value can never pass for a fresh one
	task automatic send(input logic [2:0] c, input logic [15:0] d);
		#3;
		link_valid = 1'b1;
		link_cmd = c;
		link_data = d;
		#80 link_clk = 1'b1;
		#80 link_clk = 1'b0;
		link_valid = 1'b0;
		link_cmd = ~c;
		link_data = ~d;
		#160;
	endtask
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb
	import fscr_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, irq, er;
	logic wp_n = 1'b1;
	logic link_clk, link_valid;
	logic [2:0] link_cmd;
	logic [15:0] link_data;
	logic core_busy, core_prog_start, core_erase_start;
	logic core_prog_err = 1'b0, core_erase_err = 1'b0;
	logic core_prog_susp = 1'b0, core_erase_susp = 1'b0;
	logic [1:0] latency_code;
	logic [2:0] block_protect;
	logic protect_range_placement, protect_bits_volatility, param_sector_placement;
	logic quad_enable, freeze_lock, write_in_progress;
	logic bkind = 1'b0;
	int bad_count = 0, n_tests = 0, n_starts = 0, bcnt = 0;

	always #5 pclk = ~pclk;

	fscr_host i_host (
		.link_clk(link_clk), .link_valid(link_valid), .link_cmd(link_cmd),
		.link_data(link_data));

	fscr_regs #(.REGW_CYCLES(40)) i_dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .wp_n(wp_n), .link_clk(link_clk),
		.link_valid(link_valid), .link_cmd(link_cmd), .link_data(link_data),
		.nv_status_image(8'h8c), .nv_config_image(8'h42), .core_busy(core_busy),
		.core_prog_err(core_prog_err), .core_erase_err(core_erase_err),
		.core_prog_susp(core_prog_susp), .core_erase_susp(core_erase_susp),
		.core_prog_start(core_prog_start), .core_erase_start(core_erase_start),
		.latency_code(latency_code), .protect_range_placement(protect_range_placement),
		.protect_bits_volatility(protect_bits_volatility),
		.param_sector_placement(param_sector_placement), .quad_enable(quad_enable),
		.freeze_lock(freeze_lock), .block_protect(block_protect),
		.write_in_progress(write_in_progress));

	////////////////////////////////////////////////////////////////
	// flash core stand-in: every operation runs 60 cycles and fails
	assign core_busy = (bcnt != 0);
	always @(posedge pclk) begin
		core_prog_err <= (bcnt == 1) && !bkind;
		core_erase_err <= (bcnt == 1) && bkind;
		if (core_prog_start === 1'b1 || core_erase_start === 1'b1) begin
			bcnt <= 60;
			bkind <= core_erase_start;
			n_starts <= n_starts + 1;
		end else if (bcnt != 0) begin
			bcnt <= bcnt - 1;
		end
	end

	////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask

	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// answer taken only at a rising edge; a hang is left to the watchdog
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		chk(rd, e);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask

	// irq is registered on the same edge as the enable write
	task cki(input logic e);
		repeat (2) @(negedge pclk);
		chk({31'h0, irq}, {31'h0, e});
	endtask

	task idle;
		int i;
		for (i = 0; i < 100; i++) begin
			apb(OFS_STATUS_ONE, 1'b0, 32'h0);
			if (rd[0] === 1'b0) break;
		end
	endtask

	task send(input logic [2:0] c, input logic [15:0] d);
		i_host.send(c, d);
	endtask

	task done(input string s);
		$display("test %s done", s);
	endtask

	task summarize;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		#300000;
		bad_count++;
		summarize();
	end

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		rdc(OFS_STATUS_ONE, 32'h8c);
		rdc(OFS_CONFIG_ONE, 32'h42);
		rdc(OFS_STATUS_TWO, 32'h0);
		rdc(OFS_INT_ENABLE, 32'h0);
		apb(8'h20, 1'b0, 32'h0);
		chk({31'h0, er}, 32'h1);
		wr(OFS_STATUS_ONE, 32'hff);
		rdc(OFS_STATUS_ONE, 32'h8c);
		done("reset");
		send(3'h2, 16'h00c0);
		rdc(OFS_STATUS_ONE, 32'h8c);
		rdc(OFS_CONFIG_ONE, 32'h42);
		rdc(OFS_INT_STATUS, 32'h8);
		cki(1'b0);
		wr(OFS_INT_ENABLE, 32'h8);
		cki(1'b1);
		wr(OFS_INT_CLEAR, 32'h8);
		cki(1'b0);
		rdc(OFS_INT_STATUS, 32'h0);
		done("irq");
		send(3'h0, 16'h0);
		rdc(OFS_STATUS_ONE, 32'h8e);
		@(posedge pclk);
		wp_n <= 1'b0;
		send(3'h2, 16'h00c0);
		rdc(OFS_STATUS_ONE, 32'h8e);
		rdc(OFS_CONFIG_ONE, 32'h42);
		@(posedge pclk);
		wp_n <= 1'b1;
		send(3'h2, 16'h5180);
		chk({31'h0, write_in_progress}, 32'h1);
		idle();
		rdc(OFS_STATUS_ONE, 32'h12);
		rdc(OFS_CONFIG_ONE, 32'h80);
		chk({30'h0, latency_code}, 32'h2);
		chk({31'h0, quad_enable}, 32'h0);
		rdc(OFS_INT_STATUS, 32'hc);
		wr(OFS_INT_CLEAR, 32'hf);
		done("write");
		send(3'h2, 16'h102d);
		idle();
		rdc(OFS_CONFIG_ONE, 32'h2d);
		chk({28'h0, protect_range_placement, protect_bits_volatility,
			param_sector_placement, freeze_lock}, 32'hf);
		send(3'h2, 16'h0000);
		idle();
		rdc(OFS_STATUS_ONE, 32'h12);
		rdc(OFS_CONFIG_ONE, 32'h2d);
		chk({29'h0, block_protect}, 32'h4);
		done("freeze");
		send(3'h1, 16'h0);
		rdc(OFS_STATUS_ONE, 32'h10);
		send(3'h3, 16'h0);
		chk(n_starts, 32'h0);
		send(3'h0, 16'h0);
		send(3'h3, 16'h0);
		chk({31'h0, write_in_progress}, 32'h1);
		idle();
		chk(rd & 32'hfd, 32'h50);
		send(3'h0, 16'h0);
		send(3'h4, 16'h0);
		idle();
		chk(rd & 32'hfd, 32'h70);
		chk(n_starts, 32'h2);
		send(3'h5, 16'h0);
		apb(OFS_STATUS_ONE, 1'b0, 32'h0);
		chk(rd & 32'hfd, 32'h10);
		wr(OFS_INT_CLEAR, 32'hf);
		send(3'h7, 16'h0);
		rdc(OFS_INT_STATUS, 32'h8);
		cki(1'b1);
		done("core");
		@(posedge pclk);
		core_prog_susp <= 1'b1;
		rdc(OFS_STATUS_TWO, 32'h1);
		core_prog_susp <= 1'b0;
		core_erase_susp <= 1'b1;
		rdc(OFS_STATUS_TWO, 32'h2);
		core_erase_susp <= 1'b0;
		rdc(OFS_STATUS_TWO, 32'h0);
		done("suspend");
		summarize();
	end
endmodule
